// >>> src/standby_mode_controller.v
`timescale 1ns/1ns
`include "standby_map.vh"

module standby_mode_controller #(
  parameter [16:0] WARM_CNT0 = 17'h00100,
  parameter [16:0] WARM_CNT1 = 17'h00100,
  parameter [16:0] WARM_CNT2 = 17'h04000,
  parameter [16:0] WARM_CNT3 = 17'h10000
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  input wire reduced_power_select_bit,
  input wire wait_done,
  input wire irq_req,
  input wire [3:0] irq_level,
  input wire [3:0] irq_mask,
  input wire nmi_req,
  input wire dma_bus_req,
  input wire backup_mode_pin,
  output wire [`EN_W-1:0] clk_en,
  output reg core_hold,
  output reg dma_bus_grant,
  output reg backup_ram_en,
  output reg backup_lowpower,
  output reg standby_active
);

  localparam [2:0] ST_RUN = 3'h0;
  localparam [2:0] ST_HALT = 3'h1;
  localparam [2:0] ST_DOZE = 3'h2;
  localparam [2:0] ST_SLEEP = 3'h3;
  localparam [2:0] ST_STOP = 3'h4;
  localparam [2:0] ST_WARM = 3'h5;

  reg [`CTRL_W-1:0] ctrl_q;
  reg [`IR_W-1:0] idle_run_q;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg slow_q;
  reg [16:0] warm_cnt_q;
  reg [16:0] warm_cnt_d;
  reg [16:0] warm_load;
  reg bkm_meta_q;
  reg bkm_q;
  reg wr_pend_q;
  reg [7:0] wr_addr_q;
  reg [`EN_W-1:0] en_d;
  reg [31:0] rd_word;
  wire addr_phase;
  wire wake;

  // address phase of a valid transfer to this slave
  assign addr_phase = hsel & hready & htrans[1];

  // unmasked interrupt or nmi releases any standby state
  assign wake = nmi_req | (irq_req & (irq_level > irq_mask));

  // backup mode pin passes two flops before use
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bkm_meta_q <= 1'b0;
      bkm_q <= 1'b0;
    end
    else
    begin
      bkm_meta_q <= backup_mode_pin;
      bkm_q <= bkm_meta_q;
    end
  end

  // read mux of the register file
  always @*
  begin
    rd_word = 32'h00000000;
    if (haddr[7:0] == `OFS_CTRL)
      rd_word[`CTRL_W-1:0] = ctrl_q;
    else if (haddr[7:0] == `OFS_IDLE_RUN)
      rd_word[`IR_W-1:0] = idle_run_q;
    else if (haddr[7:0] == `OFS_STATUS)
      rd_word[5:0] = {dma_bus_grant, bkm_q, slow_q, state_q};
  end

  // ahb-lite slave: zero wait state, always okay
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_q <= addr_phase & hwrite;
      if (addr_phase)
        wr_addr_q <= haddr[7:0];
      if (addr_phase & ~hwrite)
        hrdata <= rd_word;
    end
  end

  // register writes land in the data phase
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_q <= `CTRL_RST;
      idle_run_q <= `IR_RST;
    end
    else if (wr_pend_q)
    begin
      if (wr_addr_q == `OFS_CTRL)
        ctrl_q <= hwdata[`CTRL_W-1:0];
      else if (wr_addr_q == `OFS_IDLE_RUN)
        idle_run_q <= hwdata[`IR_W-1:0];
    end
  end

  // warm-up length chosen by the control field
  always @*
  begin
    case (ctrl_q[`F_WARM])
      2'h0: warm_load = WARM_CNT0;
      2'h1: warm_load = WARM_CNT1;
      2'h2: warm_load = WARM_CNT2;
      default: warm_load = WARM_CNT3;
    endcase
  end

  // standby state machine
  always @*
  begin
    state_d = state_q;
    warm_cnt_d = warm_cnt_q;
    case (state_q)
      ST_RUN:
      begin
        if (wait_done)
        begin
          if (ctrl_q[`F_MODE] == `MODE_STOP)
            state_d = ST_STOP;
          else if (ctrl_q[`F_MODE] == `MODE_SLEEP)
            state_d = ST_SLEEP;
          else if (reduced_power_select_bit)
            state_d = ST_DOZE;
          else
            state_d = ST_HALT;
        end
      end
      ST_HALT, ST_DOZE:
      begin
        if (wake)
          state_d = ST_RUN;
      end
      ST_SLEEP, ST_STOP:
      begin
        if (wake)
        begin
          if (slow_q)
            state_d = ST_RUN;
          else
          begin
            state_d = ST_WARM;
            warm_cnt_d = warm_load;
          end
        end
      end
      ST_WARM:
      begin
        if (warm_cnt_q <= 17'h00001)
          state_d = ST_RUN;
        else
          warm_cnt_d = warm_cnt_q - 17'h00001;
      end
      default:
        state_d = ST_RUN;
    endcase
  end

  // state, warm-up counter and slow mode flag
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q <= ST_RUN;
      warm_cnt_q <= 17'h00000;
      slow_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      warm_cnt_q <= warm_cnt_d;
      if (state_q == ST_RUN)
        slow_q <= ctrl_q[`F_SLOW]; // prior mode kept through standby
    end
  end

  // per-mode clock enable scheme
  always @*
  begin
    en_d = `EN_RST;
    case (state_q)
      ST_RUN:
      begin
        en_d[`EN_CPU] = 1'b1;
        en_d[`EN_CG] = 1'b1;
        en_d[`EN_INTERRUPT_CONTROLLER] = 1'b1;
        en_d[`EN_EBIF] = 1'b1;
        en_d[`EN_IO] = 1'b1;
        en_d[`EN_KEY_WAKEUP_LOGIC] = 1'b1;
        en_d[`EN_BACKUP] = 1'b1;
        en_d[`EN_PULSE] = 1'b1;
        en_d[`EN_DMA] = 1'b1;
        if (slow_q)
        begin
          en_d[`EN_OSC] = ctrl_q[`F_HOSC];
          en_d[`EN_PLL] = 1'b0;
        end
        else
        begin
          en_d[`EN_OSC] = 1'b1;
          en_d[`EN_PLL] = 1'b1;
          en_d[`EN_TIMER] = 1'b1;
          en_d[`EN_TBASE] = 1'b1;
          en_d[`EN_SERIAL] = 1'b1;
          en_d[`EN_SBUS] = 1'b1;
          en_d[`EN_ADC] = 1'b1;
          en_d[`EN_WDT] = 1'b1;
          en_d[`EN_TMR32] = 1'b1;
        end
      end
      ST_HALT, ST_DOZE:
      begin
        en_d[`EN_OSC] = 1'b1;
        en_d[`EN_PLL] = 1'b1;
        en_d[`EN_CG] = 1'b1;
        en_d[`EN_INTERRUPT_CONTROLLER] = 1'b1;
        en_d[`EN_KEY_WAKEUP_LOGIC] = 1'b1;
        en_d[`EN_BACKUP] = 1'b1;
        en_d[`EN_PULSE] = 1'b1;
        en_d[`EN_TIMER] = idle_run_q[`IR_TIMER];
        en_d[`EN_TBASE] = idle_run_q[`IR_TBASE];
        en_d[`EN_SERIAL] = idle_run_q[`IR_SERIAL];
        en_d[`EN_SBUS] = idle_run_q[`IR_SBUS];
        en_d[`EN_ADC] = idle_run_q[`IR_ADC];
        en_d[`EN_WDT] = idle_run_q[`IR_WDT];
        en_d[`EN_TMR32] = idle_run_q[`IR_TMR32];
        if (state_q == ST_DOZE)
        begin
          en_d[`EN_DMA] = 1'b1;
          en_d[`EN_EBIF] = 1'b1;
          en_d[`EN_IO] = 1'b1;
        end
      end
      ST_SLEEP:
      begin
        en_d[`EN_CG] = 1'b1;
        en_d[`EN_BACKUP] = 1'b1;
        en_d[`EN_PULSE] = 1'b1;
      end
      ST_STOP:
      begin
        en_d[`EN_KEY_WAKEUP_LOGIC] = 1'b1;
        en_d[`EN_BACKUP] = bkm_q;
      end
      ST_WARM:
      begin
        en_d[`EN_OSC] = 1'b1;
        en_d[`EN_CG] = 1'b1;
        en_d[`EN_KEY_WAKEUP_LOGIC] = 1'b1;
        en_d[`EN_BACKUP] = 1'b1;
      end
      default:
        en_d = `EN_RST;
    endcase
  end

  // enables retimed to the low clock phase
  gate_retime #(
    .WIDTH(`EN_W)
  ) u_gate_retime (
    .hclk(hclk),
    .hresetn(hresetn),
    .en_d(en_d),
    .en_q(clk_en)
  );

  // core side handshakes and backup controls
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      core_hold <= 1'b0;
      dma_bus_grant <= 1'b0;
      backup_ram_en <= 1'b0;
      backup_lowpower <= 1'b0;
      standby_active <= 1'b0;
    end
    else
    begin
      core_hold <= (state_d != ST_RUN);
      dma_bus_grant <= dma_bus_req & ((state_d == ST_RUN) | (state_d == ST_DOZE));
      backup_ram_en <= (state_d == ST_RUN) & ~slow_q;
      backup_lowpower <= bkm_q & (slow_q | (state_d == ST_STOP));
      standby_active <= (state_d != ST_RUN);
    end
  end

endmodule // standby_mode_controller

// >>> src/standby_map.vh
`ifndef STANDBY_MAP_VH
`define STANDBY_MAP_VH

// register byte offsets (low address byte)
`define OFS_CTRL 8'h00
`define OFS_IDLE_RUN 8'h04
`define OFS_STATUS 8'h08

// control register fields
`define F_MODE 1:0
`define F_WARM 3:2
`define F_SLOW 4
`define F_HOSC 5
`define CTRL_W 6
`define CTRL_RST 6'h20

// standby mode select codes
`define MODE_IDLE 2'h0
`define MODE_SLEEP 2'h1
`define MODE_STOP 2'h2

// idle run-enable register fields
`define IR_TIMER 0
`define IR_TBASE 1
`define IR_SERIAL 2
`define IR_SBUS 3
`define IR_ADC 4
`define IR_WDT 5
`define IR_TMR32 6
`define IR_W 7
`define IR_RST 7'h00

// clock enable vector bit positions
`define EN_CPU 0
`define EN_OSC 1
`define EN_PLL 2
`define EN_CG 3
`define EN_DMA 4
`define EN_INTERRUPT_CONTROLLER 5
`define EN_EBIF 6
`define EN_IO 7
`define EN_KEY_WAKEUP_LOGIC 8
`define EN_BACKUP 9
`define EN_PULSE 10
`define EN_TIMER 11
`define EN_TBASE 12
`define EN_SERIAL 13
`define EN_SBUS 14
`define EN_ADC 15
`define EN_WDT 16
`define EN_TMR32 17
`define EN_W 18
`define EN_RST 18'h00000

// ahb transfer type
`define HTRANS_NONSEQ 2'h2

`endif

// >>> src/gate_retime.v
`timescale 1ns/1ns
// re-times clock enables on the falling edge so they move only while clock is low
module gate_retime #(
  parameter WIDTH = 18
) (
  input wire hclk,
  input wire hresetn,
  input wire [WIDTH-1:0] en_d,
  output reg [WIDTH-1:0] en_q
);

  // enables change only in the clock-low phase
  always @(negedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      en_q <= {WIDTH{1'b0}};
    else
      en_q <= en_d;
  end

endmodule // gate_retime

// >>> verif/standby_mode_controller_assertions.sv
`timescale 1ns/1ns
`include "standby_map.vh"
module standby_props (
  input wire hclk,
  input wire hresetn,
  input wire hreadyout,
  input wire hresp,
  input wire wait_done,
  input wire irq_req,
  input wire nmi_req,
  input wire reduced_power_select_bit,
  input wire [`EN_W-1:0] clk_en,
  input wire core_hold,
  input wire dma_bus_grant,
  input wire standby_active
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // entry instruction seen while running
  sequence s_enter;
    !standby_active && wait_done;
  endsequence
  property p_okay;
    hreadyout && !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("bus not ready or error");
  property p_enter;
    s_enter |=> core_hold && standby_active;
  endproperty
  a_enter: assert property (p_enter) else $error("standby not entered");
  property p_stay;
    s_enter ##1 (!nmi_req && !irq_req)[*3] |-> core_hold;
  endproperty
  a_stay: assert property (p_stay) else $error("left standby unasked");
  property p_cpu;
    core_hold |-> !clk_en[`EN_CPU];
  endproperty
  a_cpu: assert property (p_cpu) else $error("cpu clocked while held");
  property p_halt;
    s_enter ##0 !reduced_power_select_bit |=> !dma_bus_grant;
  endproperty
  a_halt: assert property (p_halt) else $error("bus granted in halt");
  property p_pll;
    !clk_en[`EN_OSC] |-> !clk_en[`EN_PLL];
  endproperty
  a_pll: assert property (p_pll) else $error("pll without oscillator");
  // slow running: cpu on, pll off
  property p_slow;
    clk_en[`EN_CPU] && !clk_en[`EN_PLL] |->
      clk_en[`EN_INTERRUPT_CONTROLLER] && !clk_en[`EN_ADC] && !clk_en[`EN_TIMER];
  endproperty
  a_slow: assert property (p_slow) else $error("slow clock set wrong");
  property p_deep;
    standby_active && !clk_en[`EN_OSC] |->
      !clk_en[`EN_CPU] && !clk_en[`EN_INTERRUPT_CONTROLLER] && !clk_en[`EN_DMA];
  endproperty
  a_deep: assert property (p_deep) else $error("clock on in deep standby");
endmodule // standby_props

bind standby_mode_controller standby_props u_props (
  .hclk(hclk),
  .hresetn(hresetn),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .wait_done(wait_done),
  .irq_req(irq_req),
  .nmi_req(nmi_req),
  .reduced_power_select_bit(reduced_power_select_bit),
  .clk_en(clk_en),
  .core_hold(core_hold),
  .dma_bus_grant(dma_bus_grant),
  .standby_active(standby_active)
);

// >>> verif/core_model.sv
`timescale 1ns/1ns
module core_model (
  input wire hclk,
  input wire hresetn,
  input wire enter,
  input wire rp_in,
  input wire core_hold,
  output reg wait_done,
  output reg rp
);
  reg step_q;
  // select bit first, entry pulse one cycle later
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      step_q <= 1'h0;
      wait_done <= 1'h0;
      rp <= 1'h0;
    end
    else
    begin
      wait_done <= step_q;
      step_q <= enter && !core_hold && !step_q;
      if (enter && !core_hold)
        rp <= rp_in;
    end
  end
endmodule // core_model

// >>> verif/standby_mode_controller_tb_top.sv
`timescale 1ns/1ns
`include "standby_map.vh"
module standby_mode_controller_tb_top;
  logic hclk, hresetn, hsel, hwrite, irq_req, nmi_req, dma_req, bpin, enter, rp_in;
  logic [31:0] haddr, hwdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] irq_level, irq_mask;
  wire hreadyout, hresp, wait_done, rp, core_hold, grant, bram, blp, sact;
  wire [31:0] hrdata;
  wire [`EN_W-1:0] clk_en;
  int err_count, check_count, n;
  // distinct warm-up lengths so warm select codes 3 and 2, the two run through warm-up below, show in the cycle count
  standby_mode_controller #(.WARM_CNT0(17'h4), .WARM_CNT1(17'h5), .WARM_CNT2(17'h6),
    .WARM_CNT3(17'h7)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .reduced_power_select_bit(rp),
    .wait_done(wait_done), .irq_req(irq_req), .irq_level(irq_level), .irq_mask(irq_mask),
    .nmi_req(nmi_req), .dma_bus_req(dma_req), .backup_mode_pin(bpin), .clk_en(clk_en),
    .core_hold(core_hold), .dma_bus_grant(grant), .backup_ram_en(bram),
    .backup_lowpower(blp), .standby_active(sact));
  core_model core (.hclk(hclk), .hresetn(hresetn), .enter(enter), .rp_in(rp_in),
    .core_hold(core_hold), .wait_done(wait_done), .rp(rp));
  // free-running bus clock
  initial
  begin
    hclk = 0;
    forever #10 hclk = ~hclk;
  end
  task stop_test;
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      err_count++;
      $display("mismatch at %0t: got %h exp %h", $time, s, e);
    end
  endtask
  // one single transfer: address phase, then data phase
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'h1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= `HTRANS_NONSEQ;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    rd = hrdata;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk(rd, e);
  endtask
  task ce(input logic [17:0] m, input logic [17:0] e);
    chk({14'h0, clk_en & m}, {14'h0, e});
  endtask
  // bounded wait for the hold flag, counting cycles
  task wt(input logic v);
    n = 0;
    while (core_hold !== v && n < 40)
    begin
      @(posedge hclk);
      n++;
    end
    chk(core_hold, v);
  endtask
  task sb(input logic r, input logic [31:0] ctl);
    bus(1'h1, `OFS_CTRL, ctl);
    @(posedge hclk);
    rp_in <= r;
    enter <= 1'h1;
    @(posedge hclk);
    enter <= 1'h0;
    wt(1'h1);
  endtask
  // main sequence
  initial
  begin
    {hresetn, hsel, haddr, htrans, hwrite, hwdata, irq_req, nmi_req} = 0;
    {dma_req, bpin, enter, rp_in, irq_level, err_count, check_count} = 0;
    hsize = 3'h2;
    irq_mask = 4'h3;
    repeat (20) @(posedge hclk);
    hresetn <= 1'h1;
    repeat (2) @(posedge hclk);
    ce(18'h3ffff, 18'h3ffff);
    chk(bram, 32'h1);
    rchk(`OFS_CTRL, 32'h20);
    rchk(`OFS_IDLE_RUN, 32'h0);
    bus(1'h1, `OFS_IDLE_RUN, 32'hffffffff);
    rchk(`OFS_IDLE_RUN, 32'h7f);
    bus(1'h1, 8'h0c, 32'hffffffff);
    rchk(8'h0c, 32'h0);
    bus(1'h1, `OFS_IDLE_RUN, 32'h15);
    dma_req <= 1'h1;
    irq_req <= 1'h1;
    irq_level <= 4'h3;
    sb(1'h0, 32'h20);
    ce(18'h3f9ff, 18'h0a92e);
    chk(grant, 32'h0);
    repeat (4) @(posedge hclk);
    chk(core_hold, 32'h1);
    irq_level <= 4'h4;
    wt(1'h0);
    chk(n, 32'h2);
    irq_req <= 1'h0;
    sb(1'h1, 32'h23);
    ce(18'h3f9ff, 18'h0a9fe);
    chk(grant, 32'h1);
    nmi_req <= 1'h1;
    wt(1'h0);
    nmi_req <= 1'h0;
    sb(1'h0, 32'h2d);
    ce(18'h3ffff, 18'h00608);
    nmi_req <= 1'h1;
    wt(1'h0);
    nmi_req <= 1'h0;
    chk(n, 32'h9);
    bpin <= 1'h1;
    sb(1'h0, 32'h2a);
    repeat (3) @(posedge hclk);
    ce(18'h3ffff, 18'h00300);
    chk(blp, 32'h1);
    irq_req <= 1'h1;
    irq_level <= 4'h5;
    wt(1'h0);
    irq_req <= 1'h0;
    chk(n, 32'h8);
    bus(1'h1, `OFS_CTRL, 32'h10);
    bpin <= 1'h0;
    repeat (4) @(posedge hclk);
    ce(18'h088e5, 18'h000e1);
    chk({bram, blp}, 32'h0);
    rchk(`OFS_STATUS, 32'h28);
    sb(1'h0, 32'h12);
    nmi_req <= 1'h1;
    wt(1'h0);
    nmi_req <= 1'h0;
    chk(n, 32'h2);
    @(posedge hclk);
    ce(18'h088e5, 18'h000e1);
    stop_test;
  end
  // hang guard
  initial
  begin
    repeat (5000) @(posedge hclk);
    err_count++;
    stop_test;
  end
endmodule // standby_mode_controller_tb_top
